// ===== design/ssac_params.svh
// Constants for the simultaneous-sampling converter control and readout block
`ifndef SSAC_PARAMS_SVH
`define SSAC_PARAMS_SVH
`define SSAC_RES_BITS      16
`define SSAC_NUM_CH        8
`define SSAC_CNV_CYCLES    200
`define SSAC_BIT_CNT_W     4
`define SSAC_CH_CNT_W      3
`define SSAC_CNV_CNT_W     9
`define SSAC_DATA_RESET    16'h0000
`define SSAC_BIT_LAST      4'hF
`define SSAC_BYTE_LO_MSB   7
`define SSAC_BYTE_HI_LSB   8
`endif

// ===== design/ssac_pkg.sv
// Types for the simultaneous-sampling converter control and readout block
package ssac_pkg;
  typedef enum logic [1:0] {
    SSAC_IF_PARALLEL = 2'h1,
    SSAC_IF_SERIAL   = 2'h2,
    SSAC_IF_BYTE     = 2'h3
  } ssac_if_mode_t;

  typedef enum logic [2:0] {
    SSAC_ST_IDLE = 3'h1,
    SSAC_ST_CONV = 3'h2,
    SSAC_ST_WAIT = 3'h4
  } ssac_state_t;

  // Pin-level configuration that travels together
  typedef struct packed {
    logic reference_source_select;
    logic range_10v;
    logic power_down_n;
    logic interface_select;
    logic byte_serial_select;
    logic high_byte_first_select;
  } ssac_cfg_t;

  // Analog-side power controls
  typedef struct packed {
    logic bandgap_en;
    logic reference_drive_out;
    logic range_10v;
    logic standby;
    logic shutdown;
    logic reg_en;
  } ssac_power_t;
endpackage

// ===== design/ssac_control.sv
// Control and readout logic of the simultaneous-sampling converter
`timescale 1ns/10ps
`include "ssac_params.svh"
// Summary of operation
// [RQ1] Results are 16-bit two's complement, same for both ranges and channels.
// [RQ2] Reference select high enables internal bandgap; low powers it down.
// [RQ3] Reference select acts asynchronously, taken straight from the pin.
// [RQ4] Range input high selects ten-volt, low five-volt range for all channels.
// [RQ5] Host allows extra settling after changing range before next conversion.
// [RQ6] Power-down low enters standby or shutdown chosen by range level.
// [RQ7] Shutdown powers everything down; standby keeps reference and regulators. Here reference_drive_out still follows reference select in shutdown.
// [RQ8] Host may enter power-down anytime and waits recovery after leaving.
// [RQ9] Interface select low parallel; high gives serial or byte by byte select.
// [RQ10] Start A samples first channel half, start B second half.
// [RQ11] Host ties both conversion starts together when oversampling.
// [RQ12] Start rising edge holds the group and converts on internal clock.
// [RQ13] Host lowers conversion starts only after busy falls.
// [RQ14] Readout works whatever level the conversion starts have.
// [RQ15] Active-high asynchronous reset holds all logic while high. Here the power outputs still follow the configuration pins during reset.
// [RQ16] Host resets after power-up and after leaving shutdown.
// [RQ17] Reset aborts conversion and clears all output data registers.
// [RQ18] Host waits a minimum time from reset fall to next start.
// [RQ19] Read/clock pin is read strobe in parallel modes, serial clock otherwise.
// [RQ20] Chip select rising tri-states outputs; falling begins transfer frame.
// [RQ21] Parallel modes drive 16 or 8 lines only while select and strobe low.
// [RQ22] Serial frame start releases both serial outputs showing the MSB.
// [RQ23] Busy rises after both starts, ignores starts, falls once results latched.
// [RQ24] Byte mode order: high-byte-first select high gives upper byte first.
// [RQ25] First serial output carries first half, second output the latter half.
// [RQ26] Serial shifts MSB first, one bit per clock, ascending channel order.
module ssac_control
  import ssac_pkg::*;
#(
  parameter int NUM_CH   = `SSAC_NUM_CH,
  parameter int CNV_CYC  = `SSAC_CNV_CYCLES,
  parameter int RES_BITS = `SSAC_RES_BITS
) (
  // Clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         reset_n_i,
  input  wire logic                         device_reset_i,
  // Configuration pins
  input  wire ssac_cfg_t                    cfg_i,
  output ssac_power_t                       power_o,
  // Conversion control
  input  wire logic                         convert_start_group_a_i,
  input  wire logic                         convert_start_group_b_i,
  output logic                              busy_o,
  output logic                              conv_hold_a_o,
  output logic                              conv_hold_b_o,
  // Samples from the converter core, one word per channel
  input  wire logic [NUM_CH*RES_BITS-1:0]   core_result_i,
  // Readout pins
  input  wire logic                         chip_select_n_i,
  input  wire logic                         read_clock_i,
  output logic [RES_BITS-1:0]               parallel_result_bus_o,
  output logic [RES_BITS-1:0]               parallel_result_bus_oe_o,
  output logic                              serial_out_first_half_o,
  output logic                              serial_out_first_half_oe_o,
  output logic                              serial_out_second_half_o,
  output logic                              serial_out_second_half_oe_o,
  output logic                              first_channel_o
);

  localparam int HALF = NUM_CH / 2;

  // ****************************************************************
  // Synchronisers and edge detection
  // ****************************************************************
  // Device reset pin combined asynchronously, released synchronously
  logic rst_meta_r, rst_sync_r;
  always_ff @(posedge clk_i or negedge reset_n_i or posedge device_reset_i) begin
    if (!reset_n_i || device_reset_i) begin // RQ15
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire logic arst_n = rst_sync_r;

  logic [3:0] pin_meta_r, pin_sync_r, pin_prev_r;
  // Levels that feed clocked logic are synchronised too, against metastable decode
  logic [3:0] lvl_meta_r, lvl_sync_r;
  always_ff @(posedge clk_i or negedge arst_n) begin
    if (!arst_n) begin
      pin_meta_r <= 4'h0;
      pin_sync_r <= 4'h0;
      pin_prev_r <= 4'h0;
      lvl_meta_r <= 4'h0;
      lvl_sync_r <= 4'h0;
    end else begin
      pin_meta_r <= {convert_start_group_a_i, convert_start_group_b_i,
                     ~chip_select_n_i, read_clock_i};
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
      lvl_meta_r <= {cfg_i.power_down_n, cfg_i.interface_select,
                     cfg_i.byte_serial_select, cfg_i.high_byte_first_select};
      lvl_sync_r <= lvl_meta_r;
    end
  end
  wire logic [3:0] rise = pin_sync_r & ~pin_prev_r;
  wire logic [3:0] fall = ~pin_sync_r & pin_prev_r;
  wire logic cs_act  = pin_sync_r[1];
  wire logic cs_fall = rise[1];  // chip select asserted
  wire logic rdclk   = pin_sync_r[0];

  // ****************************************************************
  // Configuration and power
  // ****************************************************************
  function automatic ssac_if_mode_t if_decode(input ssac_cfg_t c);
    if (!c.interface_select) begin
      if_decode = SSAC_IF_PARALLEL; // RQ9
    end else if (c.byte_serial_select) begin
      if_decode = SSAC_IF_BYTE;
    end else begin
      if_decode = SSAC_IF_SERIAL;
    end
  endfunction

  ssac_cfg_t cfg_s;
  always_comb begin
    cfg_s                        = cfg_i;
    cfg_s.power_down_n           = lvl_sync_r[3];
    cfg_s.interface_select       = lvl_sync_r[2];
    cfg_s.byte_serial_select     = lvl_sync_r[1];
    cfg_s.high_byte_first_select = lvl_sync_r[0];
  end

  ssac_if_mode_t mode;
  assign mode = if_decode(cfg_s);

  // Power pins are asynchronous by nature, so they pass straight through
  always_comb begin
    power_o.bandgap_en          = cfg_i.reference_source_select &
                                  ~power_o.shutdown; // RQ2 RQ3
    power_o.reference_drive_out = cfg_i.reference_source_select; // RQ2
    power_o.range_10v           = cfg_i.range_10v; // RQ4
    power_o.standby             = ~cfg_i.power_down_n & ~cfg_i.range_10v; // RQ6
    power_o.shutdown            = ~cfg_i.power_down_n & cfg_i.range_10v; // RQ6
    power_o.reg_en              = ~power_o.shutdown; // RQ7
  end

  // ****************************************************************
  // Conversion sequencer
  // ****************************************************************
  ssac_state_t                st_r, st_nxt;
  logic [`SSAC_CNV_CNT_W-1:0] cnt_r, cnt_nxt;
  logic                       hold_a_r, hold_a_nxt, hold_b_r, hold_b_nxt;
  logic [NUM_CH*RES_BITS-1:0] data_r, data_nxt;

  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    hold_a_nxt = hold_a_r;
    hold_b_nxt = hold_b_r;
    data_nxt   = data_r;
    case (st_r)
      SSAC_ST_IDLE: begin
        if (cfg_s.power_down_n) begin
          if (rise[3]) hold_a_nxt = 1'b1; // RQ10 RQ12
          if (rise[2]) hold_b_nxt = 1'b1; // RQ10 RQ12
          if ((hold_a_r | rise[3]) && (hold_b_r | rise[2])) begin
            st_nxt  = SSAC_ST_CONV; // RQ23
            cnt_nxt = '0;
          end
        end
      end
      SSAC_ST_CONV: begin
        // Start edges are ignored here
        if (cnt_r == `SSAC_CNV_CNT_W'(CNV_CYC - 1)) begin
          data_nxt   = core_result_i; // RQ1 RQ23
          hold_a_nxt = 1'b0;
          hold_b_nxt = 1'b0;
          st_nxt     = SSAC_ST_IDLE;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: begin
        st_nxt = SSAC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n) begin
    if (!arst_n) begin // RQ17
      st_r     <= SSAC_ST_IDLE;
      cnt_r    <= '0;
      hold_a_r <= 1'b0;
      hold_b_r <= 1'b0;
      data_r   <= '0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      hold_a_r <= hold_a_nxt;
      hold_b_r <= hold_b_nxt;
      data_r   <= data_nxt;
    end
  end

  assign busy_o        = (st_r == SSAC_ST_CONV); // RQ23
  assign conv_hold_a_o = hold_a_r | busy_o;
  assign conv_hold_b_o = hold_b_r | busy_o;

  // ****************************************************************
  // Readout
  // ****************************************************************
  // Channel and bit pointers; start levels never gate readout // RQ14
  logic [`SSAC_CH_CNT_W-1:0]  ch_r, ch_nxt;
  logic [`SSAC_BIT_CNT_W-1:0] bit_r, bit_nxt;
  logic                       second_r, second_nxt;
  logic [RES_BITS-1:0]        pbus_r, pbus_nxt;
  logic                       sa_r, sa_nxt, sb_r, sb_nxt;
  logic                       first_r, first_nxt;

  function automatic logic [RES_BITS-1:0] word_of(input logic [NUM_CH*RES_BITS-1:0] d,
                                                   input int idx);
    word_of = d[idx*RES_BITS +: RES_BITS];
  endfunction

  wire logic rd_fall = fall[0] & cs_act;
  wire logic sclk_rise = rise[0] & cs_act;
  logic [RES_BITS-1:0] cur_word;
  logic [RES_BITS-1:0] wa, wb;

  always_comb begin
    ch_nxt     = ch_r;
    bit_nxt    = bit_r;
    second_nxt = second_r;
    pbus_nxt   = pbus_r;
    sa_nxt     = sa_r;
    sb_nxt     = sb_r;
    first_nxt  = first_r;
    cur_word   = word_of(data_r, int'(ch_r));
    wa         = word_of(data_r, int'(ch_r)); // RQ25
    wb         = word_of(data_r, int'(ch_r) + HALF); // RQ25
    if (cs_fall) begin // RQ20
      ch_nxt     = '0;
      bit_nxt    = '0;
      second_nxt = 1'b0;
      if (mode == SSAC_IF_SERIAL) begin
        wa        = word_of(data_r, 0);
        wb        = word_of(data_r, HALF);
        sa_nxt    = wa[RES_BITS-1]; // RQ22 RQ26
        sb_nxt    = wb[RES_BITS-1];
        first_nxt = 1'b1;
      end else begin
        first_nxt = 1'b0;
      end
    end else if (mode == SSAC_IF_SERIAL) begin
      if (sclk_rise) begin // RQ19 RQ26
        if (bit_r == `SSAC_BIT_LAST) begin
          bit_nxt   = '0;
          ch_nxt    = (int'(ch_r) == HALF - 1) ? '0 : ch_r + 1'b1;
          first_nxt = 1'b0;
        end else begin
          bit_nxt = bit_r + 1'b1;
        end
        wa     = word_of(data_r, int'(ch_nxt));
        wb     = word_of(data_r, int'(ch_nxt) + HALF);
        sa_nxt = wa[RES_BITS-1-int'(bit_nxt)];
        sb_nxt = wb[RES_BITS-1-int'(bit_nxt)];
      end
    end else if (rd_fall) begin // RQ19
      first_nxt = (ch_r == '0);
      if (mode == SSAC_IF_PARALLEL) begin
        pbus_nxt = cur_word; // RQ1
        ch_nxt   = (int'(ch_r) == NUM_CH - 1) ? '0 : ch_r + 1'b1;
      end else begin
        // Byte order follows the high-byte-first select
        pbus_nxt = '0;
        if (cfg_s.high_byte_first_select ^ second_r) begin // RQ24
          pbus_nxt[`SSAC_BYTE_LO_MSB:0] = cur_word[RES_BITS-1:`SSAC_BYTE_HI_LSB];
        end else begin
          pbus_nxt[`SSAC_BYTE_LO_MSB:0] = cur_word[`SSAC_BYTE_LO_MSB:0];
        end
        second_nxt = ~second_r;
        if (second_r) begin
          ch_nxt = (int'(ch_r) == NUM_CH - 1) ? '0 : ch_r + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n) begin
    if (!arst_n) begin // RQ17
      ch_r     <= '0;
      bit_r    <= '0;
      second_r <= 1'b0;
      pbus_r   <= `SSAC_DATA_RESET;
      sa_r     <= 1'b0;
      sb_r     <= 1'b0;
      first_r  <= 1'b0;
    end else begin
      ch_r     <= ch_nxt;
      bit_r    <= bit_nxt;
      second_r <= second_nxt;
      pbus_r   <= pbus_nxt;
      sa_r     <= sa_nxt;
      sb_r     <= sb_nxt;
      first_r  <= first_nxt;
    end
  end

  // ****************************************************************
  // Output drivers
  // ****************************************************************
  wire logic par_en = cs_act & ~rdclk & (mode != SSAC_IF_SERIAL); // RQ21
  genvar gi;
  generate
    for (gi = 0; gi < RES_BITS; gi++) begin : g_oe
      if (gi <= `SSAC_BYTE_LO_MSB) begin : g_lo
        assign parallel_result_bus_oe_o[gi] = par_en; // RQ21
      end else begin : g_hi
        assign parallel_result_bus_oe_o[gi] = par_en & (mode == SSAC_IF_PARALLEL);
      end
    end
  endgenerate

  assign parallel_result_bus_o       = pbus_r;
  assign serial_out_first_half_o     = sa_r;
  assign serial_out_second_half_o    = sb_r;
  assign serial_out_first_half_oe_o  = cs_act & (mode == SSAC_IF_SERIAL); // RQ20 RQ22
  assign serial_out_second_half_oe_o = cs_act & (mode == SSAC_IF_SERIAL); // RQ22
  assign first_channel_o             = first_r;

endmodule // ssac_control

// ===== verification/ssac_control_sva.sv
// Assertion checker for the converter control and readout block
`timescale 1ns/10ps
module ssac_control_sva
  import ssac_pkg::*;
#(
  parameter int CNV_CYC = 200
) (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        device_reset_i,
  // Pins watched
  input wire ssac_cfg_t   cfg_i,
  input wire ssac_power_t power_o,
  input wire logic        busy_o,
  input wire logic        conv_hold_a_o,
  input wire logic        conv_hold_b_o,
  input wire logic        chip_select_n_i,
  input wire logic [15:0] parallel_result_bus_o,
  input wire logic [15:0] parallel_result_bus_oe_o,
  input wire logic        serial_out_first_half_o,
  input wire logic        serial_out_first_half_oe_o,
  input wire logic        serial_out_second_half_oe_o,
  input wire logic        first_channel_o
);
  logic [15:0] bcnt_r;
  logic [15:0] bcnt_nxt;
  // Busy length is judged at its end, too long for a repetition
  always_comb bcnt_nxt = busy_o ? bcnt_r + 16'h0001 : 16'h0000;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) bcnt_r <= 16'h0000;
    else bcnt_r <= bcnt_nxt;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i || device_reset_i);
  a_busy_len: assert property ((!busy_o && bcnt_r != 16'h0000) |-> bcnt_r == CNV_CYC)
    else $error("busy length wrong");
  a_busy_holds: assert property ($rose(busy_o) |-> conv_hold_a_o && conv_hold_b_o)
    else $error("busy rose without both holds");
  a_hold_release: assert property ($fell(busy_o) |-> !conv_hold_a_o && !conv_hold_b_o)
    else $error("holds not released after busy");
  a_first_flag: assert property (
    $fell(chip_select_n_i) && cfg_i.interface_select && !cfg_i.byte_serial_select
    |-> ##[1:4] first_channel_o)
    else $error("first channel flag not set at serial frame");
  a_range_map: assert property (power_o.range_10v == cfg_i.range_10v)
    else $error("range output wrong");
  a_pd_mode: assert property (
    power_o.shutdown == (!cfg_i.power_down_n && cfg_i.range_10v) &&
    power_o.standby == (!cfg_i.power_down_n && !cfg_i.range_10v))
    else $error("power-down mode wrong");
  a_ref_sel: assert property (cfg_i.power_down_n |-> power_o.bandgap_en == cfg_i.reference_source_select)
    else $error("bandgap enable wrong");
  a_low_power: assert property (power_o.reg_en == !power_o.shutdown)
    else $error("regulator enable wrong");
  a_cs_tristate: assert property (chip_select_n_i [*4] |-> parallel_result_bus_oe_o == 16'h0000
    && !serial_out_first_half_oe_o && !serial_out_second_half_oe_o)
    else $error("outputs driven while deselected");
  a_byte_lines: assert property (cfg_i.interface_select |-> parallel_result_bus_oe_o[15:8] == 8'h00)
    else $error("upper lines driven outside parallel mode");
  a_serial_frame: assert property (
    $fell(chip_select_n_i) && cfg_i.interface_select && !cfg_i.byte_serial_select
    |-> ##[1:4] serial_out_first_half_oe_o && serial_out_second_half_oe_o)
    else $error("serial outputs not released");
  a_data_clear: assert property (disable iff (!reset_n_i)
    device_reset_i |-> parallel_result_bus_o == 16'h0000 && !busy_o && !serial_out_first_half_o)
    else $error("state not cleared by device reset");
endmodule // ssac_control_sva

bind ssac_control ssac_control_sva #(.CNV_CYC(CNV_CYC)) u_ssac_control_sva (
  .clk_i, .reset_n_i, .device_reset_i, .cfg_i, .power_o, .busy_o, .conv_hold_a_o,
  .conv_hold_b_o, .chip_select_n_i, .parallel_result_bus_o, .parallel_result_bus_oe_o,
  .serial_out_first_half_o, .serial_out_first_half_oe_o, .serial_out_second_half_oe_o,
  .first_channel_o
);

// ===== verification/ssac_host.sv
// Host controller model that frames reads in parallel, byte and serial modes
`timescale 1ns/10ps
module ssac_host (
  // Clock
  input  wire logic        clk_i,
  // Readout pins
  output logic             chip_select_n_o,
  output logic             read_clock_o,
  input  wire logic [15:0] bus_i,
  input  wire logic [15:0] bus_oe_i,
  input  wire logic        ser_first_i,
  input  wire logic        ser_second_i,
  // Words handed to the bench
  output logic [15:0]      word_o,
  output logic             word_v_o
);
  initial begin
    chip_select_n_o = 1'b1;
    read_clock_o = 1'b1;
    word_o = 16'h0000;
    word_v_o = 1'b0;
  end
  // A clock is left between words so the valid flag never toggles twice at once
  task automatic emit(input logic [15:0] w);
    word_o = w;
    word_v_o = 1'b1;
    @(posedge clk_i);
    #1 word_v_o = 1'b0;
    @(posedge clk_i);
    #1;
  endtask
  // Undriven lines read as zero through the enable mask
  task automatic par_read(input int n);
    read_clock_o = 1'b1;
    #50 chip_select_n_o = 1'b0;
    #50;
    repeat (n) begin
      read_clock_o = 1'b0;
      #60 emit(bus_i & bus_oe_i);
      read_clock_o = 1'b1;
      #60;
    end
    chip_select_n_o = 1'b1;
    #60;
  endtask
  // Link clock idles low between frames; odd offset keeps it off the system edge
  task automatic ser_read();
    logic [15:0] wa [4];
    logic [15:0] wb [4];
    read_clock_o = 1'b0;
    #103 chip_select_n_o = 1'b0;
    for (int i = 0; i < 64; i++) begin
      #62.5 wa[i/16] = {wa[i/16][14:0], ser_first_i};
      wb[i/16] = {wb[i/16][14:0], ser_second_i};
      read_clock_o = 1'b1;
      #62.5 read_clock_o = 1'b0;
    end
    #60 chip_select_n_o = 1'b1;
    for (int k = 0; k < 8; k++) emit(k < 4 ? wa[k] : wb[k-4]);
  endtask
endmodule // ssac_host

// ===== verification/tb_top.sv
// Self-checking testbench for the converter control and readout block
`timescale 1ns/10ps
module tb_top;
  import ssac_pkg::*;
  // Short conversion keeps the run brief; settle covers range and wake-up
  localparam int CNV    = 20;
  localparam int SETTLE = 8000;
  logic         clk_i;
  logic         reset_n_i;
  logic         device_reset_i;
  logic         start_a;
  logic         start_b;
  logic         busy;
  logic         cs_n;
  logic         rclk;
  logic         ser_a;
  logic         ser_b;
  logic         word_v;
  logic [127:0] core;
  logic [15:0]  bus;
  logic [15:0]  bus_oe;
  logic [15:0]  word;
  logic [15:0]  res [8];
  logic [15:0]  exp_q [$];
  ssac_cfg_t    cfg;
  ssac_power_t  pwr;
  int           n_errors = 0;
  int           checked  = 0;
  int           seed     = 32'hd57f;

  ssac_control #(.CNV_CYC(CNV)) u_ssac_control (
    .clk_i, .reset_n_i, .device_reset_i, .cfg_i(cfg), .power_o(pwr),
    .convert_start_group_a_i(start_a), .convert_start_group_b_i(start_b),
    .busy_o(busy), .conv_hold_a_o(), .conv_hold_b_o(), .core_result_i(core),
    .chip_select_n_i(cs_n), .read_clock_i(rclk), .parallel_result_bus_o(bus),
    .parallel_result_bus_oe_o(bus_oe), .serial_out_first_half_o(ser_a),
    .serial_out_first_half_oe_o(), .serial_out_second_half_o(ser_b),
    .serial_out_second_half_oe_o(), .first_channel_o()
  );
  ssac_host u_ssac_host (
    .clk_i, .chip_select_n_o(cs_n), .read_clock_o(rclk), .bus_i(bus), .bus_oe_i(bus_oe),
    .ser_first_i(ser_a), .ser_second_i(ser_b), .word_o(word), .word_v_o(word_v)
  );

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Lead 01 raises A first, 10 raises B first, 11 raises both as one signal
  task automatic convert(input logic [1:0] lead, input logic abort);
    int w;
    start_a = 1'b0;
    start_b = 1'b0;
    repeat (10) @(negedge clk_i);
    for (int k = 0; k < 8; k++) core[k*16 +: 16] = 16'($random(seed));
    start_a = lead[0];
    start_b = lead[1];
    repeat (3) @(negedge clk_i);
    start_a = 1'b1;
    start_b = 1'b1;
    w = 0;
    while (busy !== 1'b1 && w < 10) begin @(negedge clk_i); w++; end
    chk("busy rise", 16'h0001, 16'(busy));
    if (abort) begin
      device_reset_i = 1'b1;
      start_a = 1'b0;
      start_b = 1'b0;
      repeat (2) @(negedge clk_i);
      device_reset_i = 1'b0;
      chk("busy abort", 16'h0000, 16'(busy));
    end
    w = 0;
    while (busy !== 1'b0 && w < CNV + 10) begin @(negedge clk_i); w++; end
    chk("busy fall", 16'h0000, 16'(busy));
    for (int k = 0; k < 8; k++) res[k] = abort ? 16'h0000 : core[k*16 +: 16];
  endtask
  // Starts stay high during reads on purpose, except after an aborted conversion, which drops them low
  task automatic read_all(input logic [1:0] mode, input logic hb);
    @(negedge clk_i);
    cfg.interface_select = mode[1];
    cfg.byte_serial_select = mode[0];
    cfg.high_byte_first_select = hb;
    for (int k = 0; k < 8; k++) begin
      if (mode == 2'b11) begin
        exp_q.push_back({8'h00, hb ? res[k][15:8] : res[k][7:0]});
        exp_q.push_back({8'h00, hb ? res[k][7:0] : res[k][15:8]});
      end else exp_q.push_back(res[k]);
    end
    if (mode == 2'b10) u_ssac_host.ser_read();
    else u_ssac_host.par_read(mode == 2'b11 ? 16 : 8);
    $display("test readout mode %0d hb %0d done", mode, hb);
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (word_v === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_errors++;
        $display("[FAIL] word expected none seen %h", word);
      end else chk("word", exp_q.pop_front(), word);
    end
  end
  initial begin
    #300000;
    n_errors++;
    $display("[FAIL] watchdog expected finish seen timeout");
    end_sim();
  end
  initial begin
    reset_n_i = 1'b0;
    device_reset_i = 1'b1;
    start_a = 1'b0;
    start_b = 1'b0;
    core = '0;
    cfg = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    repeat (5) @(negedge clk_i);
    reset_n_i = 1'b1;
    @(negedge clk_i);
    device_reset_i = 1'b0;
    for (int m = 0; m < 8; m++) begin
      cfg.power_down_n = m[0];
      cfg.range_10v = m[1];
      cfg.reference_source_select = m[2];
      @(negedge clk_i);
      chk("power", 16'({m[1], ~m[0] & ~m[1], ~m[0] & m[1], m[0] | ~m[1]}),
          16'({pwr.range_10v, pwr.standby, pwr.shutdown, pwr.reg_en}));
      if (m[0]) chk("bandgap", 16'(m[2]), 16'(pwr.bandgap_en));
      chk("ref drive", 16'(m[2]), 16'(pwr.reference_drive_out));
    end
    cfg.range_10v = 1'b0;
    device_reset_i = 1'b1;
    @(negedge clk_i);
    device_reset_i = 1'b0;
    repeat (SETTLE) @(negedge clk_i);
    $display("test power modes done");
    convert(2'b01, 1'b0);
    read_all(2'b00, 1'b0);
    read_all(2'b11, 1'b1);
    read_all(2'b11, 1'b0);
    read_all(2'b10, 1'b0);
    convert(2'b10, 1'b1);
    read_all(2'b00, 1'b0);
    convert(2'b11, 1'b0);
    read_all(2'b10, 1'b0);
    chk("leftover", 16'h0000, 16'(exp_q.size()));
    end_sim();
  end
endmodule // tb_top
